// File: common/adc_ctrl_pkg.sv
// Constants, field layouts and state types for the converter control block.
// Assumes a 10 MHz bus clock, AHB-Lite register access and an external SAR analog core.
package adc_ctrl_pkg;

    // ==========================================================
    // Register map (byte addresses)
    localparam logic [3:0] OFS_CTRL_STATUS = 4'h0;
    localparam logic [3:0] OFS_DATA = 4'h4;
    localparam logic [3:0] OFS_CLOCK = 4'h8;
    localparam logic [3:0] OFS_PORT = 4'hC;

    // ==========================================================
    // Field positions
    localparam int CS_DONE_BIT = 7;
    localparam int CS_IRQ_EN_BIT = 6;
    localparam int CS_CONT_BIT = 5;
    localparam int CS_CHAN_LSB = 0;
    localparam int CLK_SRC_BIT = 4;
    localparam int CLK_DIV_LSB = 5;

    // ==========================================================
    // Codes and reset values
    localparam logic [4:0] CHAN_OFF = 5'h1F;
    localparam logic [4:0] CHAN_REFH = 5'h1D;
    localparam logic [4:0] CHAN_REFL = 5'h1E;
    localparam logic [4:0] CHAN_RESET = 5'h1F;
    localparam logic [2:0] DIV_RESET = 3'h0;
    localparam logic [7:0] FULL_SCALE = 8'hFF;
    localparam logic [7:0] ZERO_SCALE = 8'h00;

    // ==========================================================
    // Timing
    localparam logic [4:0] CONV_CYCLES = 5'd16;
    localparam logic [4:0] STAB_CYCLES = 5'd1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_STAB = 3'b010,
        ST_CONV = 3'b100
    } conv_state_t;

    typedef struct packed {
        logic sel;
        logic write;
        logic [3:0] addr;
    } bus_req_t;

    typedef struct packed {
        conv_state_t st;
        logic [4:0] chan;
        logic cont;
        logic irq_en;
        logic done;
        logic irq;
        logic clk_src;
        logic [2:0] div;
        logic [3:0] pre;
        logic tick;
        logic [4:0] cnt;
        logic [7:0] result;
        logic [7:0] port_out;
        logic [7:0] port_dir;
        logic [7:0] pin_meta;
        logic [7:0] pin_s2;
        logic [7:0] pin_s3;
        logic [7:0] pin_val;
        logic stop_s1;
        logic stop_s2;
        logic stop_s3;
        logic stopped;
        bus_req_t req;
        logic [31:0] hrdata;
        logic [7:0] analog_en;
        logic [7:0] pin_oe;
        logic [7:0] pin_o;
    } state_t;

endpackage : adc_ctrl_pkg

// File: hw/adc_conversion_control.sv
// Converter control: register slave, clock divider, conversion sequencer, pin sharing.
// Assumes an analog SAR core that returns a sample on the sample input when told to convert.
`timescale 1ns/1ns
module adc_conversion_control
    import adc_ctrl_pkg::*;
#(
    parameter int NPINS = 8
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic osc_clk_en,
    input wire logic stop_mode,
    input wire logic [7:0] analog_sample,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe,
    output logic [7:0] analog_en,
    output logic [4:0] selected_analog_input,
    output logic conversion_irq
);

    state_t s_r, s_nxt;

    logic chan_is_pin;
    logic wr_cs, wr_clk, wr_port, rd_data, rd_port;
    logic div_tick;
    logic [3:0] div_mask;
    logic [7:0] sel_mask;
    logic finish;

    always_comb begin
        s_nxt = s_r;
        chan_is_pin = (s_r.chan[4:3] == 2'b00);
        sel_mask = chan_is_pin ? (8'h01 << s_r.chan[2:0]) : 8'h00;

        // ==========================================================
        // AHB-Lite slave, zero wait states
        wr_cs = s_r.req.sel && s_r.req.write && (s_r.req.addr == OFS_CTRL_STATUS);
        wr_clk = s_r.req.sel && s_r.req.write && (s_r.req.addr == OFS_CLOCK);
        wr_port = s_r.req.sel && s_r.req.write && (s_r.req.addr == OFS_PORT);
        rd_data = hsel && hready && htrans[1] && !hwrite && (haddr[3:0] == OFS_DATA);
        rd_port = hsel && hready && htrans[1] && !hwrite && (haddr[3:0] == OFS_PORT);
        s_nxt.req.sel = hsel && hready && htrans[1];
        s_nxt.req.write = hwrite;
        s_nxt.req.addr = {haddr[3:2], 2'b00};
        // Read data holds until the next read, so the data phase never races it
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[3:0])
                OFS_CTRL_STATUS: s_nxt.hrdata[7:0] = {s_r.done, s_r.irq_en, s_r.cont, s_r.chan};
                OFS_DATA: s_nxt.hrdata[7:0] = s_r.result;
                OFS_CLOCK: s_nxt.hrdata[7:0] = {s_r.div, s_r.clk_src, 4'h0};
                OFS_PORT: s_nxt.hrdata[7:0] = s_r.pin_val & ~sel_mask;
                default: s_nxt.hrdata = 32'h0000_0000;
            endcase
        end
        if (wr_clk) begin
            s_nxt.div = hwdata[CLK_DIV_LSB +: 3];
            s_nxt.clk_src = hwdata[CLK_SRC_BIT];
        end
        if (wr_port) begin
            s_nxt.port_out = hwdata[7:0];
            s_nxt.port_dir = hwdata[15:8];
        end

        // ==========================================================
        // Pin synchronisers; only stages two and three are compared
        s_nxt.pin_meta = pin_i;
        s_nxt.pin_s2 = s_r.pin_meta;
        s_nxt.pin_s3 = s_r.pin_s2;
        for (int i = 0; i < NPINS; i++) begin
            if (s_r.pin_s2[i] == s_r.pin_s3[i]) begin
                s_nxt.pin_val[i] = s_r.pin_s2[i];
            end
        end
        s_nxt.stop_s1 = stop_mode;
        s_nxt.stop_s2 = s_r.stop_s1;
        s_nxt.stop_s3 = s_r.stop_s2;
        s_nxt.stopped = (s_r.stop_s2 == s_r.stop_s3) ? s_r.stop_s3 : s_r.stopped;

        // Selected pin: driver released, port registers kept but masked
        s_nxt.pin_oe = s_r.port_dir & ~sel_mask;
        s_nxt.pin_o = s_r.port_out & ~sel_mask;
        s_nxt.analog_en = sel_mask;

        // ==========================================================
        // Divider: input is bus clock or oscillator enable
        unique case (s_r.div[2] ? 2'd3 : s_r.div[1:0])
            2'd0: div_mask = 4'h0;
            2'd1: div_mask = 4'h1;
            2'd2: div_mask = 4'h3;
            default: div_mask = s_r.div[2] ? 4'hF : 4'h7;
        endcase
        div_tick = 1'b0;
        if (s_r.clk_src || osc_clk_en) begin
            s_nxt.pre = s_r.pre + 4'h1;
            if ((s_r.pre & div_mask) == div_mask) begin
                s_nxt.pre = 4'h0;
                div_tick = 1'b1;
            end
        end
        s_nxt.tick = div_tick;

        // ==========================================================
        // Sequencer
        finish = 1'b0;
        if (rd_data) begin
            s_nxt.done = 1'b0;
            s_nxt.irq = 1'b0;
        end
        if (wr_cs) begin
            s_nxt.chan = hwdata[CS_CHAN_LSB +: 5];
            s_nxt.cont = hwdata[CS_CONT_BIT];
            s_nxt.irq_en = hwdata[CS_IRQ_EN_BIT];
            s_nxt.irq = 1'b0;
            s_nxt.cnt = 5'd0;
            // Restart the divider so the first count is a whole converter clock
            s_nxt.pre = 4'h0;
            s_nxt.tick = 1'b0;
            if (hwdata[CS_CHAN_LSB +: 5] == CHAN_OFF) begin
                s_nxt.st = ST_IDLE;
            end else begin
                s_nxt.st = (s_r.chan == CHAN_OFF) ? ST_STAB : ST_CONV;
            end
        end else if (s_r.stopped) begin
            if (s_r.st == ST_CONV) begin
                s_nxt.st = ST_STAB;
            end
            s_nxt.cnt = 5'd0;
        end else if (s_r.tick) begin
            unique case (s_r.st)
                ST_IDLE: s_nxt.st = ST_IDLE;
                ST_STAB: begin
                    s_nxt.cnt = s_r.cnt + 5'd1;
                    if (s_r.cnt + 5'd1 == STAB_CYCLES) begin
                        s_nxt.st = ST_CONV;
                        s_nxt.cnt = 5'd0;
                    end
                end
                ST_CONV: begin
                    s_nxt.cnt = s_r.cnt + 5'd1;
                    if (s_r.cnt + 5'd1 == CONV_CYCLES) begin
                        finish = 1'b1;
                        s_nxt.cnt = 5'd0;
                        s_nxt.st = s_r.cont ? ST_CONV : ST_IDLE;
                    end
                end
                default: s_nxt.st = ST_IDLE;
            endcase
        end
        if (finish) begin
            if (s_r.chan == CHAN_REFH) begin
                s_nxt.result = FULL_SCALE;
            end else if (s_r.chan == CHAN_REFL) begin
                s_nxt.result = ZERO_SCALE;
            end else begin
                s_nxt.result = analog_sample;
            end
            // Set wins over a same-cycle data read
            if (s_r.irq_en) begin
                s_nxt.irq = 1'b1;
            end else begin
                s_nxt.done = 1'b1;
            end
        end
        if (s_r.irq_en || (s_r.chan == CHAN_OFF)) begin
            s_nxt.done = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: ST_IDLE, chan: CHAN_RESET, div: DIV_RESET, default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.hrdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign pin_o = s_r.pin_o;
    assign pin_oe = s_r.pin_oe;
    assign analog_en = s_r.analog_en;
    assign selected_analog_input = s_r.chan;
    assign conversion_irq = s_r.irq;

    // ==========================================================
    // Checks
    sequence conv_run_s;
        s_r.st == ST_CONV && s_r.tick && !wr_cs && !s_r.stopped;
    endsequence


    sel_pin_masked_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 ((pin_oe & $past(sel_mask)) == 8'h00)) else $error("selected pin driven");
    irq_no_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        s_r.irq_en |=> !s_r.done) else $error("done flag set in irq mode");

    off_no_irq_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.chan == CHAN_OFF && !wr_cs) |=> $stable(s_r.irq) || !s_r.irq)
        else $error("irq raised while off");

    start_on_write_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr_cs && hwdata[4:0] != CHAN_OFF) |=> s_r.st != ST_IDLE) else $error("no start");

    irq_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        (wr_cs) |=> !s_r.irq) else $error("irq not cleared on write");

    stop_abort_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.stopped && !wr_cs) |=> s_r.st != ST_CONV) else $error("conversion in stop");

    single_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        (finish && !s_r.cont && !wr_cs) |=> s_r.st == ST_IDLE) else $error("single not idle");

    cont_again_a: assert property (@(posedge clk) disable iff (!rstn)
        (finish && s_r.cont && !wr_cs) |=> s_r.st == ST_CONV) else $error("continuous stopped");

    flag_set_a: assert property (@(posedge clk) disable iff (!rstn)
        (conv_run_s ##0 finish ##0 (!s_r.irq_en && s_r.chan != CHAN_OFF)) |=> s_r.done)
        else $error("done flag missing");

    refh_full_a: assert property (@(posedge clk) disable iff (!rstn)
        (finish && s_r.chan == CHAN_REFH) |=> s_r.result == FULL_SCALE)
        else $error("upper reference not full scale");

    // ==========================================================
    // Further checks; a stop exit is only trusted when no write lands with it
    sequence stop_exit_s;
        $fell(s_r.stopped) && !$past(wr_cs);
    endsequence

    refl_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        (finish && s_r.chan == CHAN_REFL) |=> s_r.result == ZERO_SCALE)
        else $error("lower reference not zero");

    result_take_a: assert property (@(posedge clk) disable iff (!rstn)
        (finish && chan_is_pin) |=> s_r.result == $past(analog_sample))
        else $error("result not overwritten");

    rd_done_clr_a: assert property (@(posedge clk) disable iff (!rstn)
        (rd_data && !finish) |=> !s_r.done)
        else $error("done flag not cleared by read");

    done_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.done && !rd_data && !wr_cs) |=> s_r.done)
        else $error("done flag lost");

    rd_irq_clr_a: assert property (@(posedge clk) disable iff (!rstn)
        (rd_data && !finish) |=> !s_r.irq)
        else $error("irq not cleared by read");

    irq_on_end_a: assert property (@(posedge clk) disable iff (!rstn)
        (finish && s_r.irq_en) |=> s_r.irq)
        else $error("irq missing at conversion end");

    irq_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.irq && !rd_data && !wr_cs) |=> s_r.irq)
        else $error("irq dropped early");

    conv_count_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.st == ST_CONV) |-> (s_r.cnt < CONV_CYCLES))
        else $error("conversion count overrun");

    start_fresh_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_cs |=> (s_r.cnt == 5'd0 && !s_r.tick))
        else $error("conversion not restarted cleanly");

    off_idle_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.chan == CHAN_OFF) |-> (s_r.st == ST_IDLE))
        else $error("converter running while off");

    off_no_done_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.chan == CHAN_OFF) |=> !s_r.done)
        else $error("done flag while off");

    idle_stays_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.st == ST_IDLE && !wr_cs) |=> (s_r.st == ST_IDLE))
        else $error("idle converter started alone");

    stab_first_a: assert property (@(posedge clk) disable iff (!rstn)
        stop_exit_s |-> (s_r.st != ST_CONV))
        else $error("no stabilisation after stop");

    stab_to_conv_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.st == ST_STAB && s_r.tick && !wr_cs && !s_r.stopped) |=> (s_r.st == ST_CONV))
        else $error("stabilisation did not end");

    stab_count_a: assert property (@(posedge clk) disable iff (!rstn)
        (s_r.st == ST_STAB) |-> (s_r.cnt < STAB_CYCLES))
        else $error("stabilisation count overrun");

    analog_route_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 (analog_en == $past(sel_mask)))
        else $error("selected pin not routed");

    pin_o_masked_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 ((pin_o & $past(sel_mask)) == 8'h00))
        else $error("selected pin output not masked");

    unsel_port_a: assert property (@(posedge clk) disable iff (!rstn)
        ##1 (pin_oe == ($past(s_r.port_dir) & ~$past(sel_mask))))
        else $error("unselected pin direction wrong");

    port_rd_zero_a: assert property (@(posedge clk) disable iff (!rstn)
        rd_port |=> ((hrdata[7:0] & $past(sel_mask)) == 8'h00))
        else $error("selected pin read not zero");

    chan_follow_a: assert property (@(posedge clk) disable iff (!rstn)
        wr_cs |=> (selected_analog_input == $past(hwdata[4:0])))
        else $error("channel field not taken");

    div16_a: assert property (@(posedge clk) disable iff (!rstn)
        (div_tick && s_r.div[2]) |-> (s_r.pre == 4'hF))
        else $error("divide by 16 wrong");

    osc_gate_a: assert property (@(posedge clk) disable iff (!rstn)
        (!s_r.clk_src && !osc_clk_en) |=> !s_r.tick)
        else $error("tick without oscillator pulse");

endmodule : adc_conversion_control

// File: tb/analog_far_side.sv
// Far side of the converter block: shared port pins and the analog core.
// Assumes pins have pull-ups and the core answers with a fixed code per channel.
`timescale 1ns/1ns
module analog_far_side
    import adc_ctrl_pkg::*;
(
    input wire logic [4:0] sel,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    output logic [7:0] pin_i,
    output logic [7:0] analog_sample
);
    // ==========================================
    // Pin level: driven value, else the pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : 1'b1;
        end
    end
    // ==========================================
    // Core output: references give the end codes, pins a code per channel
    always_comb begin
        if (sel == CHAN_REFH) begin
            analog_sample = FULL_SCALE;
        end else if (sel == CHAN_REFL) begin
            analog_sample = ZERO_SCALE;
        end else begin
            analog_sample = {3'b101, sel};
        end
    end
endmodule : analog_far_side

// File: tb/tb.sv
// Self-checking bench for the converter control block.
// Assumes a zero-wait AHB-Lite slave and a bus-clock converter clock for timing.
`timescale 1ns/1ns
module tb;
    import adc_ctrl_pkg::*;
    logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, osc_clk_en = 0, stop_mode = 0;
    logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hreadyout, hresp, conversion_irq;
    logic [7:0] analog_sample, pin_i, pin_o, pin_oe, analog_en;
    logic [4:0] selected_analog_input;
    int err_total = 0, n_checks = 0, cyc = 0, n;
    adc_conversion_control u_dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .osc_clk_en(osc_clk_en), .stop_mode(stop_mode), .analog_sample(analog_sample),
        .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .analog_en(analog_en),
        .selected_analog_input(selected_analog_input), .conversion_irq(conversion_irq));
    analog_far_side u_far (.sel(selected_analog_input), .pin_o(pin_o), .pin_oe(pin_oe),
        .pin_i(pin_i), .analog_sample(analog_sample));
    // ==========================================
    // Clock and hang guard
    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    // ==========================================
    // Shared tasks
    task automatic chk(input logic [31:0] a, input logic [31:0] e);
        n_checks++;
        if (a !== e) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {28'h000_0000, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    // Counts cycles until the request rises, giving up at the ceiling
    task automatic wait_irq(input int mx);
        n = 0;
        while (conversion_irq !== 1'b1 && n < mx) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_irq
    task automatic done_msg(input string s);
        $display("Test %s ended, errors so far %0d", s, err_total);
    endtask : done_msg
    // ==========================================
    // Scenarios
    task automatic t_reset_map();
        xfer(0, OFS_CLOCK, 0);
        chk(q, 32'h0000_0000);
        xfer(0, 4'h0, 0);
        chk(q, {27'h0, CHAN_RESET});
        xfer(1, OFS_CTRL_STATUS, 32'h0000_005F);
        repeat (40) @(posedge clk);
        chk(conversion_irq, 1'b0);
        xfer(0, OFS_CTRL_STATUS, 0);
        chk(q[7], 1'b0);
        done_msg("reset_map");
    endtask : t_reset_map
    // Oscillator source with no oscillator pulses must not convert
    task automatic t_osc_source();
        xfer(1, OFS_CTRL_STATUS, 32'h0000_005D);
        repeat (40) @(posedge clk);
        chk(conversion_irq, 1'b0);
        done_msg("osc_source");
    endtask : t_osc_source
    task automatic t_single_flag();
        xfer(1, OFS_CLOCK, 32'h0000_0010);
        xfer(1, OFS_CTRL_STATUS, 32'h0000_001D);
        repeat (25) @(posedge clk);
        xfer(0, OFS_CTRL_STATUS, 0);
        chk(q[7], 1'b1);
        chk(conversion_irq, 1'b0);
        xfer(0, OFS_DATA, 0);
        chk(q[7:0], FULL_SCALE);
        xfer(0, OFS_CTRL_STATUS, 0);
        chk(q[7], 1'b0);
        repeat (40) @(posedge clk);
        xfer(0, OFS_CTRL_STATUS, 0);
        chk(q[7], 1'b0);
        done_msg("single_flag");
    endtask : t_single_flag
    task automatic t_irq_timing();
        xfer(1, OFS_CTRL_STATUS, 32'h0000_005E);
        wait_irq(60);
        chk(n >= 15 && n <= 21, 1'b1);
        xfer(0, OFS_CTRL_STATUS, 0);
        chk(q[7], 1'b0);
        xfer(0, OFS_DATA, 0);
        chk(q[7:0], ZERO_SCALE);
        @(posedge clk);
        chk(conversion_irq, 1'b0);
        repeat (40) @(posedge clk);
        chk(conversion_irq, 1'b0);
        done_msg("irq_timing");
    endtask : t_irq_timing
    task automatic t_continuous();
        xfer(1, OFS_CTRL_STATUS, 32'h0000_0062);
        wait_irq(60);
        chk(n < 60, 1'b1);
        xfer(1, OFS_CTRL_STATUS, 32'h0000_0062);
        @(posedge clk);
        chk(conversion_irq, 1'b0);
        repeat (60) @(posedge clk);
        xfer(0, OFS_DATA, 0);
        chk(q[7:0], 8'hA2);
        wait_irq(60);
        chk(n < 60, 1'b1);
        xfer(1, OFS_CTRL_STATUS, 32'h0000_0042);
        xfer(0, OFS_DATA, 0);
        done_msg("continuous");
    endtask : t_continuous
    task automatic t_pins();
        xfer(1, OFS_PORT, 32'h0000_FFFF);
        xfer(1, OFS_CTRL_STATUS, 32'h0000_0003);
        repeat (4) @(posedge clk);
        chk(analog_en, 8'h08);
        chk(pin_oe, 8'hF7);
        chk(selected_analog_input, 5'h03);
        xfer(0, OFS_PORT, 0);
        chk(q[7:0], 8'hF7);
        done_msg("pins");
    endtask : t_pins
    task automatic t_stop();
        xfer(1, OFS_CTRL_STATUS, 32'h0000_0041);
        repeat (5) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (40) @(posedge clk);
        chk(conversion_irq, 1'b0);
        stop_mode <= 1'b0;
        wait_irq(60);
        chk(n < 60, 1'b1);
        xfer(0, OFS_DATA, 0);
        done_msg("stop");
    endtask : t_stop
    task automatic t_divider();
        xfer(1, OFS_CLOCK, 32'h0000_0090);
        xfer(1, OFS_CTRL_STATUS, 32'h0000_0041);
        wait_irq(400);
        chk(n >= 250 && n <= 300, 1'b1);
        xfer(0, OFS_DATA, 0);
        xfer(0, 4'h0, 0);
        done_msg("divider");
    endtask : t_divider
    // ==========================================
    // Verdict, reached from the end of the run or the hang guard
    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : print_verdict
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset_map();
        t_osc_source();
        t_single_flag();
        t_irq_timing();
        t_continuous();
        t_pins();
        t_stop();
        t_divider();
        print_verdict();
    end
endmodule : tb
